// File: borc_top.sv
// breaker output relay control: trip, close, auxiliary and self-test outputs with apb settings

`timescale 1ns/10ps

module borc_top #(
	parameter int unsigned P_TICK_CYCLES = borc_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst,
	// apb slave
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// operate requests from protection features
	input  wire logic        i_trip_req,
	input  wire logic        i_close_req,
	input  wire logic [4:0]  i_aux_req,
	// breaker and logic inputs
	input  wire logic        i_breaker_closed_contact,
	input  wire logic        i_breaker_open_contact,
	input  wire logic        i_bf_expired,
	input  wire logic        i_close_inhibit,
	input  wire logic        i_reset_key,
	input  wire logic        i_reset_input,
	input  wire logic        i_selftest_fail,
	// output contacts
	output logic             o_trip,
	output logic             o_close,
	output logic [4:0]       o_aux,
	output logic             o_selftest_warn
);

	localparam int unsigned NA = borc_pkg::NUM_AUX;

	// settings
	borc_pkg::borc_ctrl_t    ctrl_reg;
	logic [9:0]              trip_seal_reg;
	logic [9:0]              close_seal_reg;
	logic [15:0]             brkop_reg;
	borc_pkg::borc_aux_cfg_t aux_cfg_reg [NA];
	logic [15:0]             dwell_reg [NA];
	logic                    host_reset_reg;

	// tick divider
	logic [17:0]             tick_cnt_reg;
	logic                    tick_reg;

	// breaker drivers
	borc_pkg::borc_brk_state_t trip_state_reg;
	borc_pkg::borc_brk_state_t trip_state_next;
	borc_pkg::borc_brk_state_t close_state_reg;
	borc_pkg::borc_brk_state_t close_state_next;
	logic [15:0]             trip_cnt_reg;
	logic [15:0]             trip_cnt_next;
	logic [15:0]             close_cnt_reg;
	logic [15:0]             close_cnt_next;

	// auxiliary channels
	logic [4:0]              aux_contact;
	logic [19:0]             aux_cfg_flat;

	// apb decode
	wire        apb_access = i_psel & i_penable;
	wire        apb_commit = apb_access & o_pready;
	wire        apb_wr     = apb_commit & i_pwrite;
	wire        hit_ctrl   = (i_paddr == borc_pkg::ADDR_CTRL);
	wire        hit_tseal  = (i_paddr == borc_pkg::ADDR_TRIP_SEAL);
	wire        hit_cseal  = (i_paddr == borc_pkg::ADDR_CLOSE_SEAL);
	wire        hit_brkop  = (i_paddr == borc_pkg::ADDR_BRKOP);
	wire        hit_auxcfg = (i_paddr == borc_pkg::ADDR_AUX_CFG);
	wire        hit_rstcmd = (i_paddr == borc_pkg::ADDR_RESET_CMD);
	wire        hit_status = (i_paddr == borc_pkg::ADDR_STATUS);
	wire [2:0]  dwell_idx  = i_paddr[4:2];
	wire        hit_dwell  = (i_paddr[7:5] == borc_pkg::ADDR_DWELL_BASE[7:5])
		&& (i_paddr[1:0] == 2'h0) && (dwell_idx < 3'(NA));
	wire        hit_any    = hit_ctrl | hit_tseal | hit_cseal | hit_brkop | hit_auxcfg
		| hit_rstcmd | hit_status | hit_dwell;

	// writes whose low 10 bits exceed the top of the range are clamped
	wire [9:0]  seal_wr    = (i_pwdata[9:0] > borc_pkg::SEAL_MAX_TICKS) ?
		borc_pkg::SEAL_MAX_TICKS : i_pwdata[9:0];

	wire [31:0] rd_status  = {22'h000000, o_selftest_warn, o_aux, o_close, o_trip,
		i_breaker_open_contact, i_breaker_closed_contact};
	wire [31:0] rd_data    =
		hit_ctrl   ? {28'h0000000, ctrl_reg} :
		hit_tseal  ? {22'h000000, trip_seal_reg} :
		hit_cseal  ? {22'h000000, close_seal_reg} :
		hit_brkop  ? {16'h0000, brkop_reg} :
		hit_auxcfg ? {12'h000, aux_cfg_flat} :
		hit_status ? rd_status :
		hit_dwell  ? {16'h0000, dwell_reg[dwell_idx]} :
		32'h00000000;

	// breaker position from whichever auxiliary contacts are assigned
	wire        aux_any    = ctrl_reg.closed_asg | ctrl_reg.open_asg;
	wire        brk_open   = ctrl_reg.open_asg ? i_breaker_open_contact : ~i_breaker_closed_contact;
	wire        brk_closed = ctrl_reg.closed_asg ? i_breaker_closed_contact : ~i_breaker_open_contact;
	wire [15:0] brkop_lim  = (brkop_reg == 16'h0000) ? borc_pkg::BRKOP_DEF_TICKS : brkop_reg;

	// close is refused while an assigned inhibit input is high
	wire        close_inh  = ctrl_reg.close_inh_en & i_close_inhibit;
	wire        close_go   = i_close_req & ~close_inh;

	// the breaker-operation timer runs only once the request has gone
	wire        trip_rel   = aux_any ?
		(~i_trip_req & (brk_open | (trip_cnt_reg >= brkop_lim))) :
		(ctrl_reg.bf_en ? i_bf_expired :
		(~i_trip_req & (trip_cnt_reg >= borc_pkg::TRIP_NOAUX_TICKS)));
	wire        close_rel  = aux_any ?
		(~i_close_req & (brk_closed | (close_cnt_reg >= brkop_lim))) :
		(close_cnt_reg >= borc_pkg::CLOSE_PULSE_TICKS);

	wire        aux_reset  = i_reset_key | i_reset_input | host_reset_reg;

	// tick divider; a shorter P_TICK_CYCLES speeds every timer alike
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			tick_cnt_reg <= 18'h00000;
			tick_reg     <= 1'b0;
		end
		else if (tick_cnt_reg == 18'(P_TICK_CYCLES - 1))
		begin
			tick_cnt_reg <= 18'h00000;
			tick_reg     <= 1'b1;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + 18'h00001;
			tick_reg     <= 1'b0;
		end
	end

	// trip driver
	always_comb
	begin
		trip_state_next = trip_state_reg;
		trip_cnt_next   = trip_cnt_reg;
		unique case (trip_state_reg)
			borc_pkg::BRK_IDLE:
			begin
				if (i_trip_req)
				begin
					trip_state_next = borc_pkg::BRK_HOLD;
					trip_cnt_next   = 16'h0000;
				end
			end
			borc_pkg::BRK_HOLD:
			begin
				if (trip_rel)
				begin
					// seal-in lengthens the pulse past the release point
					trip_state_next = (trip_seal_reg == 10'h000) ? borc_pkg::BRK_IDLE : borc_pkg::BRK_SEAL;
					trip_cnt_next   = 16'h0000;
				end
				else if (i_trip_req)
					trip_cnt_next = 16'h0000;
				else if (tick_reg && trip_cnt_reg != 16'hFFFF)
					trip_cnt_next = trip_cnt_reg + 16'h0001;
			end
			borc_pkg::BRK_SEAL:
			begin
				// a request that returns during seal-in is held again rather than dropped for a cycle
				if (i_trip_req)
				begin
					trip_state_next = borc_pkg::BRK_HOLD;
					trip_cnt_next   = 16'h0000;
				end
				else if (trip_cnt_reg >= {6'h00, trip_seal_reg})
					trip_state_next = borc_pkg::BRK_IDLE;
				else if (tick_reg)
					trip_cnt_next = trip_cnt_reg + 16'h0001;
			end
			default:
				trip_state_next = borc_pkg::BRK_IDLE;
		endcase
	end

	// close driver; the fixed pulse counts from the start, not from the request
	always_comb
	begin
		close_state_next = close_state_reg;
		close_cnt_next   = close_cnt_reg;
		unique case (close_state_reg)
			borc_pkg::BRK_IDLE:
			begin
				if (close_go)
				begin
					close_state_next = borc_pkg::BRK_HOLD;
					close_cnt_next   = 16'h0000;
				end
			end
			borc_pkg::BRK_HOLD:
			begin
				if (close_inh)
					close_state_next = borc_pkg::BRK_IDLE;
				else if (close_rel)
				begin
					close_state_next = (close_seal_reg == 10'h000) ? borc_pkg::BRK_IDLE : borc_pkg::BRK_SEAL;
					close_cnt_next   = 16'h0000;
				end
				else if (aux_any && i_close_req)
					close_cnt_next = 16'h0000;
				else if (tick_reg && close_cnt_reg != 16'hFFFF)
					close_cnt_next = close_cnt_reg + 16'h0001;
			end
			borc_pkg::BRK_SEAL:
			begin
				if (close_inh)
					close_state_next = borc_pkg::BRK_IDLE;
				else if (close_go)
				begin
					close_state_next = borc_pkg::BRK_HOLD;
					close_cnt_next   = 16'h0000;
				end
				else if (close_cnt_reg >= {6'h00, close_seal_reg})
					close_state_next = borc_pkg::BRK_IDLE;
				else if (tick_reg)
					close_cnt_next = close_cnt_reg + 16'h0001;
			end
			default:
				close_state_next = borc_pkg::BRK_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			trip_state_reg  <= borc_pkg::BRK_IDLE;
			close_state_reg <= borc_pkg::BRK_IDLE;
			trip_cnt_reg    <= 16'h0000;
			close_cnt_reg   <= 16'h0000;
			o_trip          <= 1'b0;
			o_close         <= 1'b0;
		end
		else
		begin
			trip_state_reg  <= trip_state_next;
			close_state_reg <= close_state_next;
			trip_cnt_reg    <= trip_cnt_next;
			close_cnt_reg   <= close_cnt_next;
			o_trip          <= (trip_state_next != borc_pkg::BRK_IDLE);
			o_close         <= (close_state_next != borc_pkg::BRK_IDLE);
		end
	end

	// self-test warning follows the internal fault flag, nothing to set
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			o_selftest_warn <= 1'b0;
		else
			o_selftest_warn <= i_selftest_fail;
	end

	// apb slave: one wait state so that read data comes from a flip-flop
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			o_pready  <= 1'b0;
			o_prdata  <= 32'h00000000;
			o_pslverr <= 1'b0;
		end
		else
		begin
			o_pready  <= apb_access & ~o_pready;
			o_prdata  <= (apb_access && !i_pwrite && !o_pready) ? rd_data : 32'h00000000;
			o_pslverr <= apb_access & ~o_pready & ~hit_any;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
		begin
			ctrl_reg       <= borc_pkg::CTRL_RST;
			trip_seal_reg  <= borc_pkg::SEAL_DEF_TICKS;
			close_seal_reg <= borc_pkg::SEAL_DEF_TICKS;
			brkop_reg      <= borc_pkg::BRKOP_RST;
			host_reset_reg <= 1'b0;
		end
		else
		begin
			host_reset_reg <= apb_wr & hit_rstcmd & i_pwdata[0];
			if (apb_wr && hit_ctrl)
				ctrl_reg <= borc_pkg::borc_ctrl_t'(i_pwdata[3:0]);
			if (apb_wr && hit_tseal)
				trip_seal_reg <= seal_wr;
			if (apb_wr && hit_cseal)
				close_seal_reg <= seal_wr;
			if (apb_wr && hit_brkop)
				brkop_reg <= i_pwdata[15:0];
		end
	end

	// auxiliary outputs 3 to 7 as channels 0 to 4
	genvar g;
	generate
		for (g = 0; g < NA; g++)
		begin : gen_aux
			always_ff @(posedge i_ref_clk)
			begin
				if (i_rst)
				begin
					aux_cfg_reg[g] <= borc_pkg::AUX_CFG_RST;
					dwell_reg[g]   <= borc_pkg::DWELL_RST;
				end
				else
				begin
					if (apb_wr && hit_auxcfg)
						aux_cfg_reg[g] <= borc_pkg::borc_aux_cfg_t'(i_pwdata[g*4 +: 4]);
					if (apb_wr && hit_dwell && dwell_idx == 3'(g))
						dwell_reg[g] <= i_pwdata[15:0];
				end
			end

			assign aux_cfg_flat[g*4 +: 4] = aux_cfg_reg[g];

			borc_aux_chan u_chan (
				.i_clk      (i_ref_clk),
				.i_rst      (i_rst),
				.i_tick     (tick_reg),
				.i_req      (i_aux_req[g]),
				.i_reset    (aux_reset),
				.i_cfg      (aux_cfg_reg[g]),
				.i_dwell    (dwell_reg[g]),
				.o_contact  (aux_contact[g]),
				.o_operated ()
			);
		end
	endgenerate

	// channel contacts already come from flip-flops; one more stage keeps the port registered here
	always_ff @(posedge i_ref_clk)
	begin
		if (i_rst)
			o_aux <= 5'h00;
		else
			o_aux <= aux_contact;
	end

endmodule

// File: borc_pkg.sv
// package and auxiliary output channel for the breaker output relay control block
package borc_pkg;

	// time base
	localparam int unsigned CLK_HZ           = 25_000_000;
	localparam int unsigned TICK_MS          = 10;
	localparam int unsigned TICK_CYCLES      = CLK_HZ / 1000 * TICK_MS;
	localparam int unsigned TICK_CNT_W       = 18;

	// timer figures in milliseconds
	localparam int unsigned TRIP_NOAUX_MS    = 100;
	localparam int unsigned CLOSE_PULSE_MS   = 200;
	localparam int unsigned BRKOP_DEFAULT_MS = 2000;
	localparam int unsigned SEAL_DEFAULT_MS  = 40;
	localparam int unsigned SEAL_MAX_MS      = 9990;

	// the same figures in ticks
	localparam int unsigned TMR_W            = 16;
	localparam int unsigned SEAL_W           = 10;
	localparam logic [15:0] TRIP_NOAUX_TICKS = 16'(TRIP_NOAUX_MS / TICK_MS);
	localparam logic [15:0] CLOSE_PULSE_TICKS = 16'(CLOSE_PULSE_MS / TICK_MS);
	localparam logic [15:0] BRKOP_DEF_TICKS  = 16'(BRKOP_DEFAULT_MS / TICK_MS);
	localparam logic [9:0]  SEAL_DEF_TICKS   = 10'(SEAL_DEFAULT_MS / TICK_MS);
	localparam logic [9:0]  SEAL_MAX_TICKS   = 10'(SEAL_MAX_MS / TICK_MS);

	// register map, byte addresses
	localparam int unsigned ADDR_W           = 8;
	localparam logic [7:0]  ADDR_CTRL        = 8'h00;
	localparam logic [7:0]  ADDR_TRIP_SEAL   = 8'h04;
	localparam logic [7:0]  ADDR_CLOSE_SEAL  = 8'h08;
	localparam logic [7:0]  ADDR_BRKOP       = 8'h0C;
	localparam logic [7:0]  ADDR_AUX_CFG     = 8'h10;
	localparam logic [7:0]  ADDR_RESET_CMD   = 8'h14;
	localparam logic [7:0]  ADDR_STATUS      = 8'h18;
	localparam logic [7:0]  ADDR_DWELL_BASE  = 8'h20;

	// field layout
	localparam int unsigned NUM_AUX          = 5;
	localparam int unsigned AUX_CFG_STRIDE   = 4;
	localparam logic [15:0] DWELL_RST        = 16'h0000;
	localparam logic [15:0] BRKOP_RST        = 16'h0000;

	typedef enum logic [1:0] {
		BORC_MODE_SELF  = 2'h0,
		BORC_MODE_LATCH = 2'h1,
		BORC_MODE_PULSE = 2'h2
	} borc_aux_mode_t;

	typedef struct packed {
		logic           spare;
		borc_aux_mode_t mode;
		logic           energized;
	} borc_aux_cfg_t;

	typedef struct packed {
		logic close_inh_en;
		logic bf_en;
		logic open_asg;
		logic closed_asg;
	} borc_ctrl_t;

	localparam borc_aux_cfg_t AUX_CFG_RST = '{spare: 1'b0, mode: BORC_MODE_SELF, energized: 1'b1};
	localparam borc_ctrl_t    CTRL_RST    = '{close_inh_en: 1'b0, bf_en: 1'b0, open_asg: 1'b0, closed_asg: 1'b0};

	typedef enum logic [1:0] {
		BRK_IDLE,
		BRK_HOLD,
		BRK_SEAL
	} borc_brk_state_t;

endpackage

`timescale 1ns/10ps

module borc_aux_chan (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst,
	input  wire logic                  i_tick,
	// request and reset
	input  wire logic                  i_req,
	input  wire logic                  i_reset,
	// settings
	input  wire borc_pkg::borc_aux_cfg_t i_cfg,
	input  wire logic [15:0]           i_dwell,
	// contact
	output logic                       o_contact,
	output logic                       o_operated
);

	logic        req_d_reg;
	logic        latch_reg;
	logic [15:0] dwell_reg;
	logic [15:0] dwell_next;
	logic        op_next;
	wire         req_rise   = i_req & ~req_d_reg;
	wire         dwell_run  = (dwell_reg != 16'h0000);
	// set wins over reset so a request in the reset cycle is kept
	wire         latch_next = i_req | (latch_reg & ~i_reset);

	// dwell starts on each rising edge of the request, so a new request restarts it but a held request does not
	assign dwell_next = req_rise ? i_dwell :
		((i_tick && dwell_run) ? dwell_reg - 16'h0001 : dwell_reg);

	always_comb
	begin
		unique case (i_cfg.mode)
			borc_pkg::BORC_MODE_LATCH: op_next = latch_next;
			borc_pkg::BORC_MODE_PULSE: op_next = i_req | (dwell_next != 16'h0000);
			borc_pkg::BORC_MODE_SELF:  op_next = i_req;
			default:         op_next = i_req;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			req_d_reg  <= 1'b0;
			latch_reg  <= 1'b0;
			dwell_reg  <= borc_pkg::DWELL_RST;
			o_operated <= 1'b0;
			o_contact  <= 1'b0;
		end
		else
		begin
			req_d_reg  <= i_req;
			latch_reg  <= latch_next;
			dwell_reg  <= dwell_next;
			o_operated <= op_next;
			o_contact  <= i_cfg.energized ? op_next : ~op_next;
		end
	end

endmodule

// File: borc_asserts.sv
// port checker for the breaker output relay control block
`timescale 1ns/10ps

module borc_asserts (
	// clock and reset
	input wire logic        i_ref_clk,
	input wire logic        i_rst,
	// apb
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	// trip and self-test
	input wire logic        i_trip_req,
	input wire logic        i_bf_expired,
	input wire logic        i_selftest_fail,
	input wire logic        o_trip,
	input wire logic        o_selftest_warn
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	a_pready_wait: assert property ($rose(i_penable) && i_psel |=> o_pready)
		else $error("pready missing after one wait state");
	a_pready_once: assert property (o_pready |=> !o_pready)
		else $error("pready longer than one cycle");
	a_pready_cause: assert property (o_pready |-> $past(i_penable))
		else $error("pready without access phase");
	a_rdata_idle: assert property (!o_pready |-> o_prdata == 32'h0)
		else $error("read data not zero outside answer");
	a_err_zero: assert property (o_pready && o_pslverr |-> o_prdata == 32'h0)
		else $error("error answer carries data");
	a_warn_follow: assert property (1'b1 |=> o_selftest_warn == $past(i_selftest_fail))
		else $error("warning output does not follow fault");
	a_trip_rise: assert property ($rose(i_trip_req) |=> o_trip)
		else $error("trip late after request");
	a_trip_hold: assert property (o_trip && i_trip_req && !i_bf_expired |=> o_trip)
		else $error("trip dropped while requested");
	a_trip_cause: assert property (!o_trip && !i_trip_req |=> !o_trip)
		else $error("trip without request");
	a_trip_drop: assert property ($fell(o_trip) |-> !$past(i_trip_req) || $past(i_bf_expired))
		else $error("trip fell with request still up");
endmodule

bind borc_top borc_asserts i_chk (.*);

// File: borc_breaker_model.sv
// behavioural circuit breaker with auxiliary contacts
`timescale 1ns/10ps

module borc_breaker_model #(
	parameter int P_DELAY = 5
) (
	// clock
	input  wire logic i_clk,
	// coils and fault control
	input  wire logic i_trip,
	input  wire logic i_close,
	input  wire logic i_stuck,
	// auxiliary contacts
	output logic      o_closed,
	output logic      o_open
);
	int   cnt = 0;
	logic pos = 1'b1;
	wire  move = !i_stuck && ((i_trip && pos) || (i_close && !pos));

	// a stuck mechanism never moves, so the block must time out
	always @(posedge i_clk)
	begin
		cnt <= move ? cnt + 1 : 0;
		if (move && cnt == P_DELAY)
			pos <= !pos;
	end
	assign o_closed = pos;
	assign o_open   = !pos;
endmodule

// File: borc_top_test.sv
// self-checking bench for the breaker output relay control block
`timescale 1ns/10ps

module borc_top_test;
	logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
	logic [7:0]  pa = 8'h00;
	logic [31:0] pd = 32'h0, prd, q;
	logic        rdy, err, e, trq = 0, crq = 0, bf = 0, inh = 0;
	logic        rkey = 0, rin = 0, stf = 0, stuck = 0, trip, close, warn, bc, bo;
	logic [4:0]  areq = 5'h00, aux;
	int          miscompares = 0, check_count = 0, n;

	initial forever #20 clk = ~clk;

	borc_top #(.P_TICK_CYCLES(10)) i_dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel),
		.i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pd), .o_prdata(prd),
		.o_pready(rdy), .o_pslverr(err), .i_trip_req(trq), .i_close_req(crq), .i_aux_req(areq),
		.i_breaker_closed_contact(bc), .i_breaker_open_contact(bo), .i_bf_expired(bf),
		.i_close_inhibit(inh), .i_reset_key(rkey), .i_reset_input(rin),
		.i_selftest_fail(stf), .o_trip(trip), .o_close(close), .o_aux(aux), .o_selftest_warn(warn));
	borc_breaker_model i_brk (.i_clk(clk), .i_trip(trip), .i_close(close), .i_stuck(stuck),
		.o_closed(bc), .o_open(bo));

	task results;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		check_count++;
		if (g !== x)
		begin
			$display("CHECK FAILED %0t got %h exp %h", $time, g, x);
			miscompares++;
		end
	endtask
	task rng(input int lo, input int hi);
		check_count++;
		if (n < lo || n > hi)
		begin
			$display("CHECK FAILED %0t %0d cycles not in %0d..%0d", $time, n, lo, hi);
			miscompares++;
		end
	endtask
	task cyc(input int k);
		repeat (k) @(posedge clk);
	endtask
	// the answer is awaited, never counted: only the watchdog ends a hang
	task rw(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		pa <= a;
		pd <= d;
		@(posedge clk);
		pen <= 1;
		do @(posedge clk); while (rdy !== 1'b1);
		q = prd;
		e = err;
		psel <= 0;
		pen <= 0;
	endtask
	task wt(input logic [7:0] a, input logic [31:0] d);
		rw(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
		rw(1'b0, a, 32'h0);
		chk(q, x);
		chk({31'h0, e}, {31'h0, xe});
	endtask
	task fall(input logic c, input int lim);
		n = 0;
		while (((c ? close : trip) !== 1'b0) && n < lim)
		begin
			@(posedge clk);
			n++;
		end
	endtask

	initial
	begin
		#(40 * 10000);
		miscompares++;
		results;
	end

	initial
	begin
		cyc(4);
		rst <= 0;
		rd(8'h04, 32'h4, 1'b0);
		rd(8'h08, 32'h4, 1'b0);
		rd(8'h0C, 32'h0, 1'b0);
		rd(8'h10, 32'h11111, 1'b0);
		rd(8'h40, 32'h0, 1'b1);
		wt(8'h04, 32'd1000);
		rd(8'h04, 32'd999, 1'b0);
		stf <= 1;
		cyc(3);
		chk(warn, 1);
		wt(8'h00, 32'h1);
		wt(8'h04, 32'h0);
		wt(8'h08, 32'h0);
		trq <= 1;
		cyc(20);
		chk(trip, 1);
		trq <= 0;
		fall(0, 10);
		rng(0, 3);
		crq <= 1;
		cyc(20);
		chk(close, 1);
		crq <= 0;
		fall(1, 10);
		rng(0, 3);
		wt(8'h00, 32'h3);
		wt(8'h04, 32'h4);
		trq <= 1;
		cyc(2);
		trq <= 0;
		fall(0, 100);
		rng(30, 62);
		stuck <= 1;
		wt(8'h04, 32'h0);
		wt(8'h0C, 32'h3);
		crq <= 1;
		cyc(2);
		crq <= 0;
		fall(1, 100);
		rng(20, 45);
		wt(8'h0C, 32'h0);
		crq <= 1;
		cyc(2);
		crq <= 0;
		fall(1, 2100);
		rng(1990, 2015);
		stuck <= 0;
		wt(8'h00, 32'h0);
		trq <= 1;
		cyc(2);
		trq <= 0;
		fall(0, 200);
		rng(90, 115);
		crq <= 1;
		cyc(2);
		crq <= 0;
		fall(1, 300);
		rng(190, 215);
		wt(8'h00, 32'h4);
		trq <= 1;
		cyc(20);
		bf <= 1;
		fall(0, 20);
		rng(0, 3);
		bf <= 0;
		trq <= 0;
		wt(8'h00, 32'hB);
		inh <= 1;
		crq <= 1;
		cyc(20);
		chk(close, 0);
		crq <= 0;
		inh <= 0;
		wt(8'h28, 32'h3);
		wt(8'h10, 32'h10531);
		cyc(3);
		chk(aux, 5'h08);
		areq <= 5'h1F;
		cyc(3);
		chk(aux, 5'h17);
		areq <= 5'h04;
		cyc(63);
		chk(aux, 5'h0E);
		areq <= 5'h00;
		cyc(3);
		chk(aux, 5'h0A);
		areq <= 5'h04;
		cyc(1);
		areq <= 5'h00;
		cyc(15);
		chk(aux, 5'h0E);
		cyc(30);
		chk(aux, 5'h0A);
		rkey <= 1;
		cyc(1);
		rkey <= 0;
		cyc(3);
		chk(aux, 5'h08);
		areq <= 5'h02;
		cyc(1);
		areq <= 5'h00;
		rin <= 1;
		cyc(1);
		rin <= 0;
		cyc(3);
		chk(aux, 5'h08);
		areq <= 5'h02;
		cyc(1);
		areq <= 5'h00;
		cyc(3);
		chk(aux, 5'h0A);
		wt(8'h14, 32'h1);
		cyc(3);
		chk(aux, 5'h08);
		rd(8'h28, 32'h3, 1'b0);
		rd(8'h18, 32'h282, 1'b0);
		results;
	end
endmodule
